// ### hw/wlcal_pkg.sv
// package for the write-leveling, command latency and self refresh block
// assumes one 100 MHz clock and synchronous active-high reset
package wlcal_pkg;

   localparam int CLOCK_PERIOD_NS     = 10;
   // mode register bit positions
   localparam int MR1_LEVEL_BIT       = 7;
   localparam int MR1_QOFF_BIT        = 12;
   localparam int MR2_SR_LO_BIT       = 6;
   localparam int MR2_SR_HI_BIT       = 7;
   localparam int MR_ADDR_W           = 18;
   localparam int MR_SEL_W            = 3;
   localparam logic [2:0] MR_SEL_MR1  = 3'h1;
   localparam logic [2:0] MR_SEL_MR2  = 3'h2;
   // reset values
   localparam logic       LEVEL_RESET = 1'b0;
   localparam logic       QOFF_RESET  = 1'b0;
   localparam logic [1:0] SR_RESET    = 2'h0;
   // self refresh mode codes
   localparam logic [1:0] SR_NORMAL   = 2'h0;
   localparam logic [1:0] SR_REDUCED  = 2'h1;
   localparam logic [1:0] SR_EXTENDED = 2'h2;
   localparam logic [1:0] SR_AUTO     = 2'h3;
   // fixed refresh rate codes driven to the refresh engine
   localparam logic [1:0] RATE_LOW    = 2'h0;
   localparam logic [1:0] RATE_NORMAL = 2'h1;
   localparam logic [1:0] RATE_HIGH   = 2'h2;
   // leveling output delay, figure in ns and derived cycles (max: round down, at least 1)
   localparam int LEVEL_OUT_DELAY_NS  = 9;
   localparam int LEVEL_OUT_CYCLES    =
      (LEVEL_OUT_DELAY_NS / CLOCK_PERIOD_NS) < 1 ? 1 :
      (LEVEL_OUT_DELAY_NS / CLOCK_PERIOD_NS);
   // mode change delay, figure in ns and cycles (min: round up)
   localparam int MODE_CHANGE_NS      = 120;
   localparam int MODE_CHANGE_CYCLES  =
      (MODE_CHANGE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int CNT_W               = 8;
   localparam int CAL_W               = 3;
   localparam logic [2:0] CAL_RESET   = 3'h0;

   typedef struct packed {
      logic                 valid;
      logic [MR_SEL_W-1:0]  sel;
      logic [MR_ADDR_W-1:0] addr;
   } mr_write_s;

   typedef struct packed {
      logic strobe_term_on;
      logic strobe_term_park;
      logic data_term_on;
   } term_s;

endpackage

// ### hw/edge_sync.sv
// three-stage synchroniser with agreement filter and rising edge pulse
// assumes async input; stage one is read only by stage two
`timescale 1ns/100ps
module edge_sync (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic async_in,
   output logic      level,
   output logic      rise
);

   logic s1;
   logic s2;
   logic s3;
   logic next_level;
   logic next_rise;

   always_comb begin
      next_level = level;
      if (s2 == s3) begin
         next_level = s3;
      end
      next_rise = next_level & ~level;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s1    <= 1'b0;
         s2    <= 1'b0;
         s3    <= 1'b0;
         level <= 1'b0;
         rise  <= 1'b0;
      end else begin
         s1    <= async_in;
         s2    <= s1;
         s3    <= s2;
         level <= next_level;
         rise  <= next_rise;
      end
   end

endmodule

// ### hw/wlcal_core.sv
// write leveling, chip-select-to-command latency and self refresh mode
// assumes mode register writes arrive decoded, one per cycle, and the
// link clock and strobe pins are sampled from outside this clock domain
`timescale 1ns/100ps

module wlcal_core #(
   parameter int CAL_W     = wlcal_pkg::CAL_W,
   parameter int CMD_W     = 24,
   parameter int DQ_W      = 8
) (
   input  wire logic                clock,
   input  wire logic                srst,
   input  wire wlcal_pkg::mr_write_s mr_write,
   input  wire logic [CAL_W-1:0]    cmd_latency,
   input  wire logic                chip_select_n,
   input  wire logic [CMD_W-1:0]    cmd_addr_in,
   input  wire logic                termination_pin,
   input  wire logic                link_clock,
   input  wire logic                strobe_in,
   input  wire logic                read_strobe_req,
   input  wire logic                self_refresh_entry,
   input  wire logic                self_refresh_exit,
   input  wire logic                die_hot,
   output logic                     leveling_active,
   output logic                     output_buffers_off,
   output wlcal_pkg::term_s         termination,
   output logic [DQ_W-1:0]          dq_out,
   output logic                     dq_oe,
   output logic                     read_strobe_oe,
   output logic                     ca_receivers_on,
   output logic                     cmd_valid,
   output logic [CMD_W-1:0]         cmd_captured,
   output logic [1:0]               low_power_self_refresh_select,
   output logic [1:0]               refresh_rate,
   output logic                     in_self_refresh
);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic link_level;
   logic strobe_rise;
   logic term_level;

   edge_sync u_clk_sync (
      .clock    (clock),
      .srst     (srst),
      .async_in (link_clock),
      .level    (link_level),
      .rise     ()
   );

   edge_sync u_dqs_sync (
      .clock    (clock),
      .srst     (srst),
      .async_in (strobe_in),
      .level    (),
      .rise     (strobe_rise)
   );

   edge_sync u_odt_sync (
      .clock    (clock),
      .srst     (srst),
      .async_in (termination_pin),
      .level    (term_level),
      .rise     ()
   );

   ////////////////////////////////////////////////////////////////////////
   // mode register state

   logic                           next_leveling_active;
   logic                           next_output_buffers_off;
   logic [1:0]                     next_sr_select;
   logic [wlcal_pkg::CNT_W-1:0]    settle_cnt;
   logic [wlcal_pkg::CNT_W-1:0]    next_settle_cnt;
   logic                           mr1_hit;
   logic                           mr2_hit;

   always_comb begin
      mr1_hit = mr_write.valid && (mr_write.sel == wlcal_pkg::MR_SEL_MR1);
      mr2_hit = mr_write.valid && (mr_write.sel == wlcal_pkg::MR_SEL_MR2);
      next_leveling_active    = leveling_active;
      next_output_buffers_off = output_buffers_off;
      next_sr_select          = low_power_self_refresh_select;
      next_settle_cnt         = settle_cnt;
      if (settle_cnt != '0) begin
         next_settle_cnt = settle_cnt - 1'b1;
      end
      if (mr1_hit) begin
         next_leveling_active =
            mr_write.addr[wlcal_pkg::MR1_LEVEL_BIT];
         next_output_buffers_off =
            mr_write.addr[wlcal_pkg::MR1_QOFF_BIT];
         // after entry, leveling pins stay quiet for the mode change delay; exit is not gated
         next_settle_cnt =
            wlcal_pkg::CNT_W'(wlcal_pkg::MODE_CHANGE_CYCLES);
      end
      // manual setting may only change outside self refresh
      if (mr2_hit && !in_self_refresh) begin
         next_sr_select = {mr_write.addr[wlcal_pkg::MR2_SR_HI_BIT],
                           mr_write.addr[wlcal_pkg::MR2_SR_LO_BIT]};
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         leveling_active               <= wlcal_pkg::LEVEL_RESET;
         output_buffers_off            <= wlcal_pkg::QOFF_RESET;
         low_power_self_refresh_select <= wlcal_pkg::SR_RESET;
         settle_cnt                    <= '0;
      end else begin
         leveling_active               <= next_leveling_active;
         output_buffers_off            <= next_output_buffers_off;
         low_power_self_refresh_select <= next_sr_select;
         settle_cnt                    <= next_settle_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // termination and leveling feedback

   wlcal_pkg::term_s              next_termination;
   logic [DQ_W-1:0]               next_dq_out;
   logic                          next_dq_oe;
   logic                          next_read_strobe_oe;
   logic                          sampled;
   logic                          next_sampled;
   logic [wlcal_pkg::CNT_W-1:0]   wlo_cnt;
   logic [wlcal_pkg::CNT_W-1:0]   next_wlo_cnt;
   logic                          term_ready;

   always_comb begin
      term_ready   = leveling_active && (settle_cnt == '0);
      next_sampled = sampled;
      next_wlo_cnt = wlo_cnt;
      next_dq_out  = dq_out;
      next_dq_oe   = 1'b0;
      next_termination = '0;
      if (term_ready) begin
         // strobe pair always terminated: nominal or park by pin level
         next_termination.strobe_term_on   = term_level;
         next_termination.strobe_term_park = ~term_level;
         next_termination.data_term_on     = 1'b0;
      end else if (!leveling_active) begin
         // termination timing is independent of command latency
         next_termination.data_term_on = term_level;
      end
      if (wlo_cnt != '0) begin
         next_wlo_cnt = wlo_cnt - 1'b1;
      end
      if (term_ready && strobe_rise) begin
         next_sampled = link_level;
         next_wlo_cnt =
            wlcal_pkg::CNT_W'(wlcal_pkg::LEVEL_OUT_CYCLES);
      end
      if (wlo_cnt == 8'h01) begin
         // every bit from one flop stage keeps skew inside the window
         next_dq_out = {DQ_W{sampled}};
      end
      // data pins driven only while leveling settled and outputs on
      if (term_ready && !output_buffers_off) begin
         next_dq_oe = 1'b1;
      end
      next_read_strobe_oe = read_strobe_req && !leveling_active;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         termination    <= '0;
         dq_out         <= '0;
         dq_oe          <= 1'b0;
         read_strobe_oe <= 1'b0;
         sampled        <= 1'b0;
         wlo_cnt        <= '0;
      end else begin
         termination    <= next_termination;
         dq_out         <= next_dq_out;
         dq_oe          <= next_dq_oe;
         read_strobe_oe <= next_read_strobe_oe;
         sampled        <= next_sampled;
         wlo_cnt        <= next_wlo_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // chip-select-to-command latency

   logic [CAL_W-1:0]     lat_cnt;
   logic [CAL_W-1:0]     next_lat_cnt;
   logic                 next_cmd_valid;
   logic [CMD_W-1:0]     next_cmd_captured;
   logic                 next_ca_on;
   logic                 pending;
   logic                 next_pending;

   always_comb begin
      next_lat_cnt      = lat_cnt;
      next_pending      = pending;
      next_cmd_valid    = 1'b0;
      next_cmd_captured = cmd_captured;
      next_ca_on        = 1'b1;
      if (cmd_latency == '0) begin
         if (!chip_select_n) begin
            next_cmd_valid    = 1'b1;
            next_cmd_captured = cmd_addr_in;
         end
      end else begin
         if (!chip_select_n && !pending) begin
            next_pending = 1'b1;
            next_lat_cnt = cmd_latency - 1'b1;
         end else if (pending && lat_cnt != '0) begin
            next_lat_cnt = lat_cnt - 1'b1;
         end else if (pending) begin
            next_cmd_valid    = 1'b1;
            next_cmd_captured = cmd_addr_in;
            next_pending      = !chip_select_n;
            next_lat_cnt      = cmd_latency - 1'b1;
         end
         // receivers rest once idle and select is high; kept on in a run
         next_ca_on = next_pending || !chip_select_n;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         lat_cnt         <= wlcal_pkg::CAL_RESET;
         pending         <= 1'b0;
         cmd_valid       <= 1'b0;
         cmd_captured    <= '0;
         ca_receivers_on <= 1'b1;
      end else begin
         lat_cnt         <= next_lat_cnt;
         pending         <= next_pending;
         cmd_valid       <= next_cmd_valid;
         cmd_captured    <= next_cmd_captured;
         ca_receivers_on <= next_ca_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // self refresh rate selection

   logic       next_in_sr;
   logic [1:0] next_rate;
   logic [1:0] latched_mode;
   logic [1:0] next_latched_mode;

   always_comb begin
      next_in_sr        = in_self_refresh;
      next_latched_mode = latched_mode;
      if (self_refresh_entry && !in_self_refresh) begin
         next_in_sr        = 1'b1;
         next_latched_mode = low_power_self_refresh_select;
      end else if (self_refresh_exit) begin
         next_in_sr = 1'b0;
      end
      case (latched_mode)
         wlcal_pkg::SR_NORMAL:   next_rate = wlcal_pkg::RATE_NORMAL;
         wlcal_pkg::SR_REDUCED:  next_rate = wlcal_pkg::RATE_LOW;
         wlcal_pkg::SR_EXTENDED: next_rate = wlcal_pkg::RATE_HIGH;
         wlcal_pkg::SR_AUTO:     next_rate = die_hot ?
            wlcal_pkg::RATE_HIGH : wlcal_pkg::RATE_LOW;
         default:                next_rate = wlcal_pkg::RATE_NORMAL;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         in_self_refresh <= 1'b0;
         latched_mode    <= wlcal_pkg::SR_RESET;
         refresh_rate    <= wlcal_pkg::RATE_NORMAL;
      end else begin
         in_self_refresh <= next_in_sr;
         latched_mode    <= next_latched_mode;
         refresh_rate    <= next_rate;
      end
   end

endmodule

// ### testbench/wlcal_core_asserts.sv
// checker bound to wlcal_core: mode bits, leveling gating, latency, refresh
// assumes one clock domain with synchronous active-high srst
`timescale 1ns/100ps
module wlcal_core_asserts #(
   parameter int CAL_W = 3,
   parameter int CMD_W = 24,
   parameter int DQ_W  = 8
) (
   input wire logic                 clock,
   input wire logic                 srst,
   input wire wlcal_pkg::mr_write_s mr_write,
   input wire logic [CAL_W-1:0]     cmd_latency,
   input wire logic                 chip_select_n,
   input wire logic [CMD_W-1:0]     cmd_addr_in,
   input wire logic                 die_hot,
   input wire logic                 leveling_active,
   input wire logic                 output_buffers_off,
   input wire wlcal_pkg::term_s     termination,
   input wire logic [DQ_W-1:0]      dq_out,
   input wire logic                 read_strobe_oe,
   input wire logic                 cmd_valid,
   input wire logic [CMD_W-1:0]     cmd_captured,
   input wire logic [1:0]           low_power_self_refresh_select,
   input wire logic [1:0]           refresh_rate,
   input wire logic                 in_self_refresh
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   logic wr1;
   logic wr2;
   assign wr1 = mr_write.valid && mr_write.sel == wlcal_pkg::MR_SEL_MR1;
   assign wr2 = mr_write.valid && mr_write.sel == wlcal_pkg::MR_SEL_MR2;
   // one cycle of grace on entry, the gating is registered
   sequence lvl_held;
      leveling_active && $past(leveling_active);
   endsequence
   AST_LEVEL_BIT: assert property (
      wr1 |=> leveling_active == $past(mr_write.addr[7]))
      else $error("leveling enable not taken");
   AST_QOFF_BIT: assert property (
      wr1 |=> output_buffers_off == $past(mr_write.addr[12]))
      else $error("output buffer bit not taken");
   AST_DATA_TERM: assert property (
      lvl_held |-> !termination.data_term_on)
      else $error("data termination on while leveling");
   AST_RD_STROBE: assert property (
      lvl_held |-> !read_strobe_oe)
      else $error("read strobe driven while leveling");
   AST_DQ_SAME: assert property (
      dq_out == {DQ_W{dq_out[0]}})
      else $error("feedback differs between data bits");
   AST_CMD_NOW: assert property (
      !chip_select_n && cmd_latency == 0 |=>
         cmd_valid && cmd_captured == $past(cmd_addr_in))
      else $error("zero latency command not captured");
   AST_CMD_LAT3: assert property (
      !chip_select_n && cmd_latency == 3 |-> ##1 !cmd_valid [*3] ##1
         (cmd_valid && cmd_captured == $past(cmd_addr_in)))
      else $error("latency three command misplaced");
   AST_SR_MODE: assert property (
      wr2 && !in_self_refresh |=> low_power_self_refresh_select ==
         $past({mr_write.addr[7], mr_write.addr[6]}))
      else $error("self refresh mode not taken");
   AST_SR_HOLD: assert property (
      in_self_refresh && $past(in_self_refresh) |->
         $stable(low_power_self_refresh_select))
      else $error("self refresh mode changed during refresh");
   AST_AUTO_RATE: assert property (
      in_self_refresh && $past(in_self_refresh, 3) && $stable(die_hot) &&
      die_hot == $past(die_hot, 2) &&
      low_power_self_refresh_select == wlcal_pkg::SR_AUTO |->
      refresh_rate == (die_hot ? wlcal_pkg::RATE_HIGH : wlcal_pkg::RATE_LOW))
      else $error("auto refresh rate ignores temperature");
   COV_LEVEL: cover property ($rose(leveling_active));
   COV_CMD: cover property (cmd_valid);
   COV_SR: cover property ($rose(in_self_refresh));
endmodule
bind wlcal_core wlcal_core_asserts #(.CAL_W(CAL_W), .CMD_W(CMD_W), .DQ_W(DQ_W))
   u_wlcal_core_asserts (.clock, .srst, .mr_write, .cmd_latency,
   .chip_select_n, .cmd_addr_in, .die_hot, .leveling_active,
   .output_buffers_off, .termination, .dq_out, .read_strobe_oe, .cmd_valid,
   .cmd_captured, .low_power_self_refresh_select, .refresh_rate,
   .in_self_refresh);

// ### testbench/ddr_ctrl_model.sv
// far-side controller model: free-running link clock and leveling strobe
// assumes pulse() is called only while drive is high
`timescale 1ns/100ps
module ddr_ctrl_model (
   input  wire logic drive,
   output logic      link_clock,
   output logic      strobe_in
);
   logic s = 1'b0;
   initial link_clock = 1'b0;
   always #62.5 link_clock = ~link_clock;
   // strobe held low from the moment it is driven; released pair rests high
   assign strobe_in = drive ? s : 1'b1;
   // one strobe rise d ns after a clock rise, wide enough for the sampler
   task pulse(input int d);
      @(posedge link_clock);
      #(d);
      s = 1'b1;
      #40;
      s = 1'b0;
   endtask
endmodule

// ### testbench/wlcal_core_tb_top.sv
// self-checking bench for wlcal_core: mode bits, leveling feedback,
// command latency and self refresh modes
// assumes package, core, checker and controller model compiled before it
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module wlcal_core_tb_top;
   logic                 clock = 1'b0, srst = 1'b1, chip_select_n = 1'b1;
   logic                 termination_pin = 1'b0, read_strobe_req = 1'b1;
   logic                 die_hot = 1'b0, strobe_drive = 1'b0;
   logic                 self_refresh_entry = 1'b0, self_refresh_exit = 1'b0;
   logic [2:0]           cmd_latency = 3'h0;
   logic [23:0]          cmd_addr_in = 24'h000000;
   wlcal_pkg::mr_write_s mr_write = '0;
   logic                 link_clock, strobe_in, leveling_active, dq_oe;
   logic                 output_buffers_off, read_strobe_oe, cmd_valid;
   logic                 ca_receivers_on, in_self_refresh, e, p;
   logic [23:0]          cmd_captured;
   logic [7:0]           dq_out;
   logic [1:0]           low_power_self_refresh_select, refresh_rate;
   wlcal_pkg::term_s     termination;
   int                   seed = 64, n_errors, tests_run, cycles, k, d;
   int                   lock, lats [3] = '{0, 3, 7};

   wlcal_core u_wlcal_core (.clock, .srst, .mr_write, .cmd_latency,
      .chip_select_n, .cmd_addr_in, .termination_pin, .link_clock,
      .strobe_in, .read_strobe_req, .self_refresh_entry, .self_refresh_exit,
      .die_hot, .leveling_active, .output_buffers_off, .termination, .dq_out,
      .dq_oe, .read_strobe_oe, .ca_receivers_on, .cmd_valid, .cmd_captured,
      .low_power_self_refresh_select, .refresh_rate, .in_self_refresh);
   ddr_ctrl_model u_ddr_ctrl_model (.drive(strobe_drive), .link_clock,
      .strobe_in);

   always #5 clock = ~clock;
   // the sequence needs well under a thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task tally_and_finish();
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task wait_n(input int n);
      repeat (n) @(negedge clock);
   endtask
   task mr(input logic [2:0] sel, input logic [17:0] a);
      @(negedge clock);
      mr_write = '{1'b1, sel, a};
      @(negedge clock);
      mr_write.valid = 1'b0;
   endtask
   task sr_pulse(input logic enter);
      @(negedge clock);
      self_refresh_entry = enter;
      self_refresh_exit = !enter;
      @(negedge clock);
      self_refresh_entry = 1'b0;
      self_refresh_exit = 1'b0;
   endtask
   // bus value changes every cycle so a capture on the wrong edge shows
   // cmd_valid registers on the capture edge, so it shows at the next fall
   task cal_cmd(input int n);
      logic [23:0] q [$];
      q.delete();
      @(negedge clock);
      chip_select_n = 1'b0;
      for (int i = 0; i <= n; i++) begin
         `CHK(cmd_valid, 1'b0)
         if (i > 0) `CHK(ca_receivers_on, 1'b1)
         cmd_addr_in = 24'($random(seed));
         q.push_back(cmd_addr_in);
         @(negedge clock);
         chip_select_n = 1'b1;
      end
      `CHK(cmd_valid, 1'b1)
      `CHK(cmd_captured, q[n])
      `CHK(ca_receivers_on, 1'(n == 0))
   endtask
   function automatic logic [1:0] rate(input int c, input logic hot);
      case (c)
         0: rate = wlcal_pkg::RATE_NORMAL;
         1: rate = wlcal_pkg::RATE_LOW;
         2: rate = wlcal_pkg::RATE_HIGH;
         default: rate = hot ? wlcal_pkg::RATE_HIGH : wlcal_pkg::RATE_LOW;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(negedge clock);
      srst = 1'b0;
      `CHK(leveling_active, 1'b0)
      `CHK(refresh_rate, wlcal_pkg::RATE_NORMAL)
      `CHK(ca_receivers_on, 1'b1)
      $display("test reset done");
      for (k = 0; k < 4; k++) begin
         mr(wlcal_pkg::MR_SEL_MR1, {5'h00, k[1], 4'h0, k[0], 7'h00});
         `CHK(leveling_active, k[0])
         `CHK(output_buffers_off, k[1])
      end
      $display("test mode bits done");
      mr(wlcal_pkg::MR_SEL_MR1, 18'h00080);
      wait_n(16);
      termination_pin = 1'b1;
      wait_n(8);
      `CHK(termination, 3'b100)
      termination_pin = 1'b0;
      wait_n(8);
      `CHK(termination, 3'b010)
      `CHK(read_strobe_oe, 1'b0)
      strobe_drive = 1'b1;
      lock = -1;
      p = 1'b1;
      // strobe delays kept clear of clock edges by more than a sample period
      for (k = 0; k < 8; k++) begin
         d = 20 + 30 * k;
         u_ddr_ctrl_model.pulse(d);
         wait_n(15);
         e = (d % 125) < 63;
         `CHK(dq_out, {8{e}})
         if (e && !p && lock < 0) lock = k;
         p = e;
      end
      `CHK(dq_oe, 1'b1)
      $display("test leveling done, lock at step %0d", lock);
      // strobes released before the exit write, termination pin already low
      strobe_drive = 1'b0;
      mr(wlcal_pkg::MR_SEL_MR1, 18'h00000);
      `CHK(leveling_active, 1'b0)
      wait_n(13);
      `CHK(dq_oe, 1'b0)
      `CHK(read_strobe_oe, 1'b1)
      for (k = 0; k < 3; k++) begin
         cmd_latency = 3'(lats[k]);
         wait_n(20);
         cal_cmd(lats[k]);
      end
      $display("test command latency done");
      for (k = 0; k < 4; k++) begin
         mr(wlcal_pkg::MR_SEL_MR2, 18'(k) << 6);
         `CHK(low_power_self_refresh_select, 2'(k))
         die_hot = 1'($random(seed));
         sr_pulse(1'b1);
         wait_n(3);
         `CHK(in_self_refresh, 1'b1)
         `CHK(refresh_rate, rate(k, die_hot))
         mr(wlcal_pkg::MR_SEL_MR2, 18'(k ^ 1) << 6);
         `CHK(low_power_self_refresh_select, 2'(k))
         die_hot = ~die_hot;
         wait_n(3);
         `CHK(refresh_rate, rate(k, die_hot))
         sr_pulse(1'b0);
         wait_n(3);
         `CHK(in_self_refresh, 1'b0)
      end
      $display("test self refresh done");
      tally_and_finish();
   end
endmodule
